/* sim/alert_limit_registers_tb.sv */
// Self-checking testbench of the alert limit register bank
`timescale 1ns/100ps
module alert_limit_registers_tb;
   import alr_pkg::*;
   localparam logic [15:0] MK = 16'h4142;   // Arbitrary value
   localparam logic [11:0] DK = 12'hA5C;    // Arbitrary value
   localparam logic [3:0]  RK = 4'h3;       // Arbitrary value
   typedef struct {logic [5:0] a; logic [15:0] d; logic [15:0] e;} alr_reg_row_t;
   typedef struct {logic [5:0] a; logic [15:0] t; int k; logic [23:0] r; int f; logic e;} alr_flag_row_t;

   logic                   mclk_i = 1'b0;
   logic                   rst_i = 1'b1;
   logic [ADDR_W-1:0]      addr;
   logic                   wr;
   logic [DATA_W-1:0]      wdata;
   logic                   rd;
   logic [DATA_W-1:0]      rdata;
   logic                   rvalid;
   logic                   rng = 1'b0;
   logic                   latch = 1'b0;
   logic                   fread = 1'b0;
   logic [SHUNT_RES_W-1:0] sres = '0;
   logic [BUS_RES_W-1:0]   bres = '0;
   logic [TEMP_RES_W-1:0]  tres = '0;
   logic [POWER_RES_W-1:0] pres = '0;
   logic                   sv = 1'b0;
   logic                   bv = 1'b0;
   logic                   tv = 1'b0;
   logic                   pv = 1'b0;
   logic [5:0]             flg;
   int                     err_total = 0;
   int                     num_checks = 0;

   // Write rows: written value and value read back
   alr_reg_row_t regs[9] = '{'{6'h0C, 16'h1234, 16'h1234}, '{6'h0D, 16'hFEDC, 16'hFEDC},
      '{6'h0E, 16'hFFFF, 16'h7FFF}, '{6'h0F, 16'h8001, 16'h0001}, '{6'h10, 16'h8123, 16'h8123},
      '{6'h11, 16'h00AB, 16'h00AB}, '{6'h3E, 16'h0000, MK}, '{6'h3F, 16'h0000, {DK, RK}},
      '{6'h20, 16'hFFFF, 16'h0000}};
   // Reset values
   alr_reg_row_t rrows[6] = '{'{6'h0C, 16'h0, 16'h7FFF}, '{6'h0D, 16'h0, 16'h8000},
      '{6'h0E, 16'h0, 16'h7FFF}, '{6'h0F, 16'h0, 16'h0000}, '{6'h10, 16'h0, 16'h07FF},
      '{6'h11, 16'h0, 16'hFFFF}};
   // Flag rows: threshold, result kind and value, flag index, expected flag
   alr_flag_row_t frows[16] = '{'{6'h0C, 16'h0010, 0, 24'h00100, 5, 1'b0},
      '{6'h0C, 16'h0010, 0, 24'h00101, 5, 1'b1}, '{6'h0C, 16'h0010, 0, 24'h80000, 5, 1'b0},
      '{6'h0D, 16'hFFF0, 0, 24'hFFF00, 4, 1'b0}, '{6'h0D, 16'hFFF0, 0, 24'hFFEFF, 4, 1'b1},
      '{6'h0E, 16'h0100, 1, 24'h01000, 3, 1'b0}, '{6'h0E, 16'h0100, 1, 24'h01001, 3, 1'b1},
      '{6'h0E, 16'h7FFF, 1, 24'hFFFFF, 3, 1'b1}, '{6'h0F, 16'h0100, 1, 24'h00FFF, 2, 1'b1},
      '{6'h0F, 16'h0100, 1, 24'h01000, 2, 1'b0}, '{6'h10, 16'h0050, 2, 24'h00051, 1, 1'b1},
      '{6'h10, 16'h0050, 2, 24'h08000, 1, 1'b0}, '{6'h10, 16'h0050, 2, 24'h00050, 1, 1'b0},
      '{6'h11, 16'h0001, 3, 24'h00100, 0, 1'b0}, '{6'h11, 16'h0001, 3, 24'h00101, 0, 1'b1},
      '{6'h11, 16'h8000, 3, 24'hFFFFFF, 0, 1'b1}};

   // Clock
   always #2.5 mclk_i = ~mclk_i;

   alr_limit_bank #(.MAKER_CODE(MK), .DIE_CODE(DK), .REV_CODE(RK)) alr_limit_bank_inst (
      .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .shunt_range_select_i(rng),
      .alert_latch_select_i(latch), .flag_reg_read_i(fread), .shunt_result_i(sres),
      .shunt_valid_i(sv), .bus_result_i(bres), .bus_valid_i(bv), .die_temperature_result_i(tres),
      .temp_valid_i(tv), .power_result_i(pres), .power_valid_i(pv), .shunt_over_flag_o(flg[5]),
      .shunt_under_flag_o(flg[4]), .bus_over_flag_o(flg[3]), .bus_under_flag_o(flg[2]),
      .temperature_over_flag_o(flg[1]), .power_over_flag_o(flg[0]));

   alr_host_model alr_host_model_inst (
      .mclk_i(mclk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
      .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

   // Compare tasks
   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask

   // Read one register and compare data and valid
   task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
      logic [15:0] d;
      logic        ok;
      alr_host_model_inst.read_reg(a, d, ok);
      chk1("read valid", 1'b1, ok);
      chk16("read data", e, d);
   endtask

   // One measurement result with its one-cycle valid pulse
   task automatic meas(input int k, input logic [23:0] r);
      @(negedge mclk_i);
      case (k)
         0: begin
            sres = r[19:0];
            sv = 1'b1;
         end
         1: begin
            bres = r[19:0];
            bv = 1'b1;
         end
         2: begin
            tres = r[15:0];
            tv = 1'b1;
         end
         default: begin
            pres = r;
            pv = 1'b1;
         end
      endcase
      @(negedge mclk_i);
      {sv, bv, tv, pv} = 4'h0;
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #20000;
      err_total++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      repeat (16) @(negedge mclk_i);
      rst_i = 1'b0;
      foreach (regs[i]) begin
         alr_host_model_inst.write_reg(regs[i].a, regs[i].d);
         rdchk(regs[i].a, regs[i].e);
      end
      for (int r = 0; r < 2; r++) begin
         rng = r[0];
         foreach (frows[i]) begin
            alr_host_model_inst.write_reg(frows[i].a, frows[i].t);
            meas(frows[i].k, frows[i].r);
            chk1("flag", frows[i].e, flg[frows[i].f]);
         end
      end
      // Negative over threshold trips on a zero shunt result
      alr_host_model_inst.write_reg(6'h0D, 16'hFFF0);
      alr_host_model_inst.write_reg(6'h0C, 16'hFFFF);
      meas(0, 24'h0);
      chk1("shunt over at zero", 1'b1, flg[5]);
      // Threshold change alone must not re-evaluate the flag
      alr_host_model_inst.write_reg(6'h0C, 16'h7FFF);
      chk1("flag held without result", 1'b1, flg[5]);
      // Latched mode holds until the flag register read
      latch = 1'b1;
      alr_host_model_inst.write_reg(6'h11, 16'h0001);
      meas(3, 24'h000101);
      meas(2, 24'h000051);
      meas(3, 24'h0);
      chk1("latched power flag", 1'b1, flg[0]);
      chk1("latched temp flag", 1'b1, flg[1]);
      @(negedge mclk_i);
      fread = 1'b1;
      @(negedge mclk_i);
      fread = 1'b0;
      chk1("latched flag cleared", 1'b0, flg[0]);
      chk1("latched temp cleared", 1'b0, flg[1]);
      // A new hit in the cycle of the flag read keeps the flag set
      @(negedge mclk_i);
      sres = 20'hFFEFF;
      sv = 1'b1;
      fread = 1'b1;
      @(negedge mclk_i);
      sv = 1'b0;
      fread = 1'b0;
      chk1("set beats read clear", 1'b1, flg[4]);
      // Second reset in mid-run restores every threshold
      rst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      rst_i = 1'b0;
      chk16("flags after reset", 16'h0, {10'h0, flg});
      foreach (rrows[i]) begin
         rdchk(rrows[i].a, rrows[i].e);
      end
      tally_and_finish();
   end
endmodule

/* sim/alr_host_model.sv */
// Host model that reaches the limit register bank through its word port
`timescale 1ns/100ps
module alr_host_model (
   // Clock
   input  wire logic                       mclk_i,
   // Word port toward the bank
   output logic [alr_pkg::ADDR_W-1:0]      reg_addr_o,
   output logic                            reg_wr_o,
   output logic [alr_pkg::DATA_W-1:0]      reg_wdata_o,
   output logic                            reg_rd_o,
   input  wire logic [alr_pkg::DATA_W-1:0] reg_rdata_i,
   input  wire logic                       reg_rvalid_i
);
   import alr_pkg::*;

   // Idle port at time zero
   initial begin
      reg_addr_o = '0;
      reg_wr_o = 1'b0;
      reg_wdata_o = '0;
      reg_rd_o = 1'b0;
   end

   // One write strobe; the idle bus is scrambled so stale values cannot pass
   task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge mclk_i);
      reg_wr_o = 1'b0;
      reg_addr_o = ~a;
      reg_wdata_o = ~d;
   endtask

   // One read strobe; data and valid are taken in the cycle after it
   task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge mclk_i);
      reg_rd_o = 1'b0;
      reg_addr_o = ~a;
      ok = reg_rvalid_i;
      d = reg_rdata_i;
   endtask
endmodule

/* src/alr_alert_flag.sv */
// One diagnostic flag: transparent, or latched and cleared by a flag register read
`timescale 1ns/100ps
module alr_alert_flag (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_i,
   // Event and control
   input  wire logic sample_i,
   input  wire logic hit_i,
   input  wire logic latch_i,
   input  wire logic read_clr_i,
   // Flag
   output logic      flag_o
);
   logic flag;
   logic next_flag;

   // Transparent follows each sample; latched sets and holds, a set beats a read clear
   always_comb begin
      next_flag = flag;
      if (!latch_i) begin
         if (sample_i) next_flag = hit_i;
      end else if (sample_i && hit_i) begin
         next_flag = 1'b1;
      end else if (read_clr_i) begin
         next_flag = 1'b0;
      end
   end

   // Flag register
   always_ff @(posedge mclk_i) begin
      if (rst_i) flag <= 1'b0;
      else       flag <= next_flag;
   end

   assign flag_o = flag;
endmodule

/* src/alr_limit_bank.sv */
// Limit threshold and identification register bank with threshold comparison and flags
//
// Functional notes
// - Shunt over threshold, signed, reset 7FFF, compared.
// - Negative over threshold trips on zero shunt.
// - Shunt threshold LSB follows range select.
// - Shunt under threshold, signed, reset 8000, compared.
// - Bus over threshold, 15 unsigned bits, 7FFF.
// - Bus under threshold, 15 unsigned bits, zero.
// - Bus thresholds 3.125 mV, range independent.
// - Bus threshold bit 15 always reads zero.
// - Power over threshold unsigned, 256 LSBs each.
// - Maker code read only at 3E.
// - Die and revision codes at 3F.
// - Each crossing sets flag; latched cleared by read.
// - Range select chooses wide or narrow shunt range.
`timescale 1ns/100ps
module alr_limit_bank #(
   parameter logic [15:0] MAKER_CODE = 16'h4142,   // Arbitrary value
   parameter logic [11:0] DIE_CODE   = 12'hA5C,    // Arbitrary value
   parameter logic [3:0]  REV_CODE   = 4'h3        // Arbitrary value
) (
   // Clock and reset
   input  wire logic                         mclk_i,
   input  wire logic                         rst_i,
   // Register port from the serial interface
   input  wire logic [alr_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic                         reg_wr_i,
   input  wire logic [alr_pkg::DATA_W-1:0]   reg_wdata_i,
   input  wire logic                         reg_rd_i,
   output logic      [alr_pkg::DATA_W-1:0]   reg_rdata_o,
   output logic                              reg_rvalid_o,
   // Configuration and flag register controls
   input  wire logic                         shunt_range_select_i,
   input  wire logic                         alert_latch_select_i,
   input  wire logic                         flag_reg_read_i,
   // Measurement results
   input  wire logic [alr_pkg::SHUNT_RES_W-1:0] shunt_result_i,
   input  wire logic                            shunt_valid_i,
   input  wire logic [alr_pkg::BUS_RES_W-1:0]   bus_result_i,
   input  wire logic                            bus_valid_i,
   input  wire logic [alr_pkg::TEMP_RES_W-1:0]  die_temperature_result_i,
   input  wire logic                            temp_valid_i,
   input  wire logic [alr_pkg::POWER_RES_W-1:0] power_result_i,
   input  wire logic                            power_valid_i,
   // Diagnostic flags
   output logic                              shunt_over_flag_o,
   output logic                              shunt_under_flag_o,
   output logic                              bus_over_flag_o,
   output logic                              bus_under_flag_o,
   output logic                              temperature_over_flag_o,
   output logic                              power_over_flag_o
);
   import alr_pkg::*;

   logic [15:0]           shunt_over_threshold;
   logic [15:0]           shunt_under_threshold;
   logic [14:0]           bus_over_threshold;
   logic [14:0]           bus_under_threshold;
   logic [15:0]           temperature_over_threshold;
   logic [15:0]           power_over_threshold;
   logic [15:0]           next_shunt_over;
   logic [15:0]           next_shunt_under;
   logic [14:0]           next_bus_over;
   logic [14:0]           next_bus_under;
   logic [15:0]           next_temp_over;
   logic [15:0]           next_power_over;
   logic [DATA_W-1:0]     rdata;
   logic                  rvalid;
   logic [DATA_W-1:0]     next_rdata;
   logic [SHUNT_RES_W-1:0] shunt_over_ext;
   logic [SHUNT_RES_W-1:0] shunt_under_ext;
   logic [BUS_RES_W-1:0]   bus_over_ext;
   logic [BUS_RES_W-1:0]   bus_under_ext;
   logic [POWER_RES_W-1:0] power_over_ext;
   logic                  shunt_above;
   logic                  shunt_below;
   logic                  bus_above;
   logic                  bus_below;
   logic                  temp_above;
   logic                  power_above;

   // Threshold writes; identification registers ignore writes
   always_comb begin
      next_shunt_over  = shunt_over_threshold;
      next_shunt_under = shunt_under_threshold;
      next_bus_over    = bus_over_threshold;
      next_bus_under   = bus_under_threshold;
      next_temp_over   = temperature_over_threshold;
      next_power_over  = power_over_threshold;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            OFS_SHUNT_OVER:  next_shunt_over  = reg_wdata_i;
            OFS_SHUNT_UNDER: next_shunt_under = reg_wdata_i;
            OFS_BUS_OVER:    next_bus_over    = reg_wdata_i[BUS_FIELD_MSB:0];
            OFS_BUS_UNDER:   next_bus_under   = reg_wdata_i[BUS_FIELD_MSB:0];
            OFS_TEMP_OVER:   next_temp_over   = reg_wdata_i;
            OFS_POWER_OVER:  next_power_over  = reg_wdata_i;
            default: ;
         endcase
      end
   end

   // Threshold registers with documented reset values
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         shunt_over_threshold       <= RST_SHUNT_OVER;
         shunt_under_threshold      <= RST_SHUNT_UNDER;
         bus_over_threshold         <= RST_BUS_OVER;
         bus_under_threshold        <= RST_BUS_UNDER;
         temperature_over_threshold <= RST_TEMP_OVER;
         power_over_threshold       <= RST_POWER_OVER;
      end else begin
         shunt_over_threshold       <= next_shunt_over;
         shunt_under_threshold      <= next_shunt_under;
         bus_over_threshold         <= next_bus_over;
         bus_under_threshold        <= next_bus_under;
         temperature_over_threshold <= next_temp_over;
         power_over_threshold       <= next_power_over;
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      next_rdata = '0;
      unique case (reg_addr_i)
         OFS_SHUNT_OVER:  next_rdata = shunt_over_threshold;
         OFS_SHUNT_UNDER: next_rdata = shunt_under_threshold;
         OFS_BUS_OVER:    next_rdata = {1'b0, bus_over_threshold};
         OFS_BUS_UNDER:   next_rdata = {1'b0, bus_under_threshold};
         OFS_TEMP_OVER:   next_rdata = temperature_over_threshold;
         OFS_POWER_OVER:  next_rdata = power_over_threshold;
         OFS_MAKER_ID:    next_rdata = MAKER_CODE;
         OFS_PART_REVISION_CODE_FIELD: next_rdata = {DIE_CODE, REV_CODE};
         default:         next_rdata = '0;
      endcase
      if (!reg_rd_i) next_rdata = rdata;
   end

   // Read data register, one cycle after the read strobe
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata  <= '0;
         rvalid <= 1'b0;
      end else begin
         rdata  <= next_rdata;
         rvalid <= reg_rd_i;
      end
   end

   assign reg_rdata_o  = rdata;
   assign reg_rvalid_o = rvalid;

   // Align thresholds to result LSBs; shunt scale picked by range select
   always_comb begin
      if (shunt_range_select_i) begin
         shunt_over_ext  = SHUNT_RES_W'($signed(shunt_over_threshold)) <<< SHUNT_SHIFT_NARROW;
         shunt_under_ext = SHUNT_RES_W'($signed(shunt_under_threshold)) <<< SHUNT_SHIFT_NARROW;
      end else begin
         shunt_over_ext  = SHUNT_RES_W'($signed(shunt_over_threshold)) <<< SHUNT_SHIFT_WIDE;
         shunt_under_ext = SHUNT_RES_W'($signed(shunt_under_threshold)) <<< SHUNT_SHIFT_WIDE;
      end
      bus_over_ext   = BUS_RES_W'(bus_over_threshold) << BUS_SHIFT;
      bus_under_ext  = BUS_RES_W'(bus_under_threshold) << BUS_SHIFT;
      power_over_ext = POWER_RES_W'(power_over_threshold) << POWER_SHIFT;
   end

   // Strict comparators, signedness per quantity
   alr_limit_cmp #(.W(SHUNT_RES_W), .SIGNED(1'b1)) u_cmp_shunt_over (
      .result_i    (shunt_result_i),
      .threshold_i (shunt_over_ext),
      .above_o     (shunt_above),
      .below_o     ()
   );
   alr_limit_cmp #(.W(SHUNT_RES_W), .SIGNED(1'b1)) u_cmp_shunt_under (
      .result_i    (shunt_result_i),
      .threshold_i (shunt_under_ext),
      .above_o     (),
      .below_o     (shunt_below)
   );
   alr_limit_cmp #(.W(BUS_RES_W), .SIGNED(1'b0)) u_cmp_bus_over (
      .result_i    (bus_result_i),
      .threshold_i (bus_over_ext),
      .above_o     (bus_above),
      .below_o     ()
   );
   alr_limit_cmp #(.W(BUS_RES_W), .SIGNED(1'b0)) u_cmp_bus_under (
      .result_i    (bus_result_i),
      .threshold_i (bus_under_ext),
      .above_o     (),
      .below_o     (bus_below)
   );
   alr_limit_cmp #(.W(TEMP_RES_W), .SIGNED(1'b1)) u_cmp_temp (
      .result_i    (die_temperature_result_i),
      .threshold_i (temperature_over_threshold),
      .above_o     (temp_above),
      .below_o     ()
   );
   alr_limit_cmp #(.W(POWER_RES_W), .SIGNED(1'b0)) u_cmp_power (
      .result_i    (power_result_i),
      .threshold_i (power_over_ext),
      .above_o     (power_above),
      .below_o     ()
   );

   // Flags sampled on each new result of the matching kind
   alr_alert_flag u_flag_shunt_over (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (shunt_valid_i), .hit_i (shunt_above),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (shunt_over_flag_o)
   );
   alr_alert_flag u_flag_shunt_under (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (shunt_valid_i), .hit_i (shunt_below),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (shunt_under_flag_o)
   );
   alr_alert_flag u_flag_bus_over (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (bus_valid_i), .hit_i (bus_above),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (bus_over_flag_o)
   );
   alr_alert_flag u_flag_bus_under (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (bus_valid_i), .hit_i (bus_below),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (bus_under_flag_o)
   );
   alr_alert_flag u_flag_temp_over (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (temp_valid_i), .hit_i (temp_above),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (temperature_over_flag_o)
   );
   alr_alert_flag u_flag_power_over (
      .mclk_i (mclk_i), .rst_i (rst_i), .sample_i (power_valid_i), .hit_i (power_above),
      .latch_i (alert_latch_select_i), .read_clr_i (flag_reg_read_i), .flag_o (power_over_flag_o)
   );

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd_id;
      reg_rd_i && reg_addr_i == OFS_PART_REVISION_CODE_FIELD;
   endsequence

   sequence s_rd_bus;
      reg_rd_i && (reg_addr_i == OFS_BUS_OVER || reg_addr_i == OFS_BUS_UNDER);
   endsequence

   a_reset_values: assert property (
      $fell(rst_i) |-> shunt_over_threshold == 16'h7FFF && shunt_under_threshold == 16'h8000
         && bus_over_threshold == 15'h7FFF && bus_under_threshold == 15'h0000
         && temperature_over_threshold == 16'h07FF && power_over_threshold == 16'hFFFF)
      else $error("threshold reset value wrong");

   a_maker_read: assert property (
      reg_rd_i && reg_addr_i == OFS_MAKER_ID ##1 1'b1 |-> rvalid && rdata == MAKER_CODE)
      else $error("maker code read wrong");

   a_partrev_read: assert property (
      s_rd_id |=> rvalid && rdata[15:DIE_FIELD_LSB] == DIE_CODE && rdata[REV_FIELD_MSB:0] == REV_CODE)
      else $error("die or revision code read wrong");

   a_bus_reserved: assert property (s_rd_bus |=> rdata[15] == 1'b0)
      else $error("bus threshold bit 15 not zero");

   a_write_back: assert property (
      reg_wr_i && reg_addr_i == OFS_SHUNT_UNDER ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == OFS_SHUNT_UNDER
         && !reg_wr_i |=> rdata == $past(reg_wdata_i, 3))
      else $error("shunt under threshold write lost");

   a_zero_trips: assert property (
      shunt_valid_i && shunt_result_i == '0 && shunt_over_threshold[15] |=> shunt_over_flag_o)
      else $error("zero shunt did not trip negative threshold");

   a_bus_over_cmp: assert property (
      bus_valid_i && bus_result_i > {1'b0, bus_over_threshold, 4'h0} |=> bus_over_flag_o)
      else $error("bus over flag missing");

   a_bus_under_cmp: assert property (
      bus_valid_i && bus_result_i < {1'b0, bus_under_threshold, 4'h0} |=> bus_under_flag_o)
      else $error("bus under flag missing");

   a_temp_over_cmp: assert property (
      temp_valid_i && $signed(die_temperature_result_i) > $signed(temperature_over_threshold)
         |=> temperature_over_flag_o)
      else $error("temperature over flag missing");

   a_power_over_cmp: assert property (
      power_valid_i && power_result_i > {power_over_threshold, 8'h00} |=> power_over_flag_o)
      else $error("power over flag missing");

   a_power_hold: assert property (
      !alert_latch_select_i && !power_valid_i && !$past(alert_latch_select_i)
         |=> power_over_flag_o == $past(power_over_flag_o))
      else $error("power flag changed without a result");

   a_latch_clear: assert property (
      alert_latch_select_i && flag_reg_read_i && !temp_valid_i && temperature_over_flag_o
         |=> !temperature_over_flag_o)
      else $error("latched temperature flag not cleared by read");

   a_set_beats_clr: assert property (
      alert_latch_select_i && flag_reg_read_i && shunt_valid_i && shunt_below
         |=> shunt_under_flag_o [*1])
      else $error("set lost against read clear");
endmodule

/* src/alr_limit_cmp.sv */
// Strict greater/less comparator of a measurement result against an aligned threshold
`timescale 1ns/100ps
module alr_limit_cmp #(
   parameter int W      = 20,
   parameter bit SIGNED = 1'b1
) (
   // Operands
   input  wire logic [W-1:0] result_i,
   input  wire logic [W-1:0] threshold_i,
   // Outcomes
   output logic              above_o,
   output logic              below_o
);
   // Signed or unsigned strict compare
   always_comb begin
      if (SIGNED) begin
         above_o = $signed(result_i) > $signed(threshold_i);
         below_o = $signed(result_i) < $signed(threshold_i);
      end else begin
         above_o = result_i > threshold_i;
         below_o = result_i < threshold_i;
      end
   end
endmodule

/* src/alr_pkg.sv */
// Package of offsets, reset values, field positions and scaling for the alert limit register bank
package alr_pkg;
   // Register port geometry
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_SHUNT_OVER   = 6'h0C;
   localparam logic [ADDR_W-1:0] OFS_SHUNT_UNDER  = 6'h0D;
   localparam logic [ADDR_W-1:0] OFS_BUS_OVER     = 6'h0E;
   localparam logic [ADDR_W-1:0] OFS_BUS_UNDER    = 6'h0F;
   localparam logic [ADDR_W-1:0] OFS_TEMP_OVER    = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_POWER_OVER   = 6'h11;
   localparam logic [ADDR_W-1:0] OFS_MAKER_ID     = 6'h3E;
   localparam logic [ADDR_W-1:0] OFS_PART_REVISION_CODE_FIELD  = 6'h3F;

   // Reset values
   localparam logic [15:0] RST_SHUNT_OVER  = 16'h7FFF;
   localparam logic [15:0] RST_SHUNT_UNDER = 16'h8000;
   localparam logic [14:0] RST_BUS_OVER    = 15'h7FFF;
   localparam logic [14:0] RST_BUS_UNDER   = 15'h0000;
   localparam logic [15:0] RST_TEMP_OVER   = 16'h07FF;
   localparam logic [15:0] RST_POWER_OVER  = 16'hFFFF;

   // Field positions
   localparam int BUS_FIELD_MSB   = 14;
   localparam int DIE_FIELD_LSB   = 4;
   localparam int REV_FIELD_MSB   = 3;

   // Measurement result widths
   localparam int SHUNT_RES_W = 20;
   localparam int BUS_RES_W   = 20;
   localparam int TEMP_RES_W  = 16;
   localparam int POWER_RES_W = 24;

   // Threshold-to-result alignment shifts (threshold LSB / result LSB as power of two)
   localparam int SHUNT_SHIFT_WIDE   = 4;   // 5 uV over 312.5 nV
   localparam int SHUNT_SHIFT_NARROW = 4;   // 1.25 uV over 78.125 nV
   localparam int BUS_SHIFT          = 4;   // 3.125 mV over 195.3125 uV
   localparam int POWER_SHIFT        = 8;   // 256 power LSBs per count
endpackage
